/* tb_vid_startup_sequencer.sv */
// self-checking bench for the start-up sequencer
`timescale 1ns/1ps
module tb_vid_startup_sequencer;
  import vss_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic [4:0]  code_req = 5'h01;
  logic        on_req = 1'b1;
  logic        af_req = 1'b0;
  logic        fde_req = 1'b1;
  logic        rise_in = 1'b0;
  logic        fall_in = 1'b0;
  logic        sw_in = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [16:0] dac_setpoint_out;
  logic        power_good_out, power_good_oe, continuous_conduction_mode, diode_emulation_mode;
  logic [1:0]  window_select_out;
  logic        audio_filter_out, pg_line;
  logic [4:0]  voltage_id_bits;
  logic        regulator_on_in, audio_filter_select, emulation_select;
  int          n_fail = 0;
  int          compares = 0;

  always #12.5 core_clk = ~core_clk;

  vss_host_model vss_host_model_inst (.core_clk(core_clk), .nrst(nrst), .code_req(code_req), .on_req(on_req),
    .af_req(af_req), .fde_req(fde_req), .power_good_out(power_good_out), .power_good_oe(power_good_oe),
    .voltage_id_bits(voltage_id_bits), .regulator_on_in(regulator_on_in),
    .audio_filter_select(audio_filter_select), .emulation_select(emulation_select), .pg_line(pg_line));

  vss_sequencer vss_sequencer_inst (.core_clk(core_clk), .nrst(nrst), .voltage_id_bits(voltage_id_bits),
    .regulator_on_in(regulator_on_in), .supply_rise_threshold(rise_in), .supply_fall_threshold(fall_in),
    .switch_cycle_in(sw_in), .audio_filter_select(audio_filter_select), .emulation_select(emulation_select),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .dac_setpoint_out(dac_setpoint_out), .power_good_out(power_good_out), .power_good_oe(power_good_oe),
    .continuous_conduction_mode(continuous_conduction_mode), .diode_emulation_mode(diode_emulation_mode),
    .window_select_out(window_select_out), .audio_filter_out(audio_filter_out));

  // expected set-point in 10 uV units, built from the code table figures
  function automatic logic [16:0] exp_sp(input logic [4:0] c);
    return (c == 5'h1F) ? 17'h0A0F0 : 17'(17'h1F6EE - c * 17'h00A0F);
  endfunction : exp_sp

  // expected {dem, window, audio filter}
  function automatic logic [3:0] exp_mode(input logic [4:0] c, input logic fde, input logic af);
    if (!c[4]) return fde ? 4'hA : 4'h0;
    if (!af) return 4'hC;
    return fde ? 4'hA : 4'hB;
  endfunction : exp_mode

  task automatic stop_test;
    $display("checks %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one Avalon transfer; entered just after a rising edge
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] rd);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !we;
    avs_write <= we;
    @(posedge core_clk);
    // no cycle count assumed: only the watchdog ends a stuck wait
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus

  task automatic wait_sp(input logic [4:0] c);
    int i;
    for (i = 0; i < 3000 && dac_setpoint_out !== exp_sp(c); i++) @(posedge core_clk);
    chk("setpoint", 32'(exp_sp(c)), 32'(dac_setpoint_out));
  endtask : wait_sp

  task automatic t_reset;
    repeat (10) @(posedge core_clk);
    chk("oe in reset", 32'h1, 32'(power_good_oe));
    chk("sp in reset", 32'h0, 32'(dac_setpoint_out));
    nrst <= 1'b1;
    @(posedge core_clk);
  endtask : t_reset

  task automatic t_startup;
    logic [31:0] rd;
    int i;
    repeat (20) @(posedge core_clk);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF, rd);
    chk("state before por", 32'h1, 32'(rd[4:0]));
    chk("sp before por", 32'h0, 32'(dac_setpoint_out));
    rise_in <= 1'b1;
    repeat (3900) @(posedge core_clk);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF, rd);
    chk("state in delay", 32'h2, 32'(rd[4:0]));
    chk("sp in delay", 32'h0, 32'(dac_setpoint_out));
    chk("ccm in delay", 32'h1, 32'(continuous_conduction_mode));
    repeat (200) @(posedge core_clk);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF, rd);
    chk("state in ramp", 32'h4, 32'(rd[4:0]));
    chk("ccm in ramp", 32'h1, 32'(continuous_conduction_mode));
    wait_sp(5'h01);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF, rd);
    chk("state in count", 32'h8, 32'(rd[4:0]));
    for (i = 1; i <= 13; i++) begin
      sw_in <= 1'b1;
      @(posedge core_clk);
      sw_in <= 1'b0;
      repeat (4) @(posedge core_clk);
      if (i == 12) chk("oe after 12", 32'h1, 32'(power_good_oe));
      if (i == 12) chk("ccm in count", 32'h1, 32'(continuous_conduction_mode));
    end
    chk("oe after 13", 32'h0, 32'(power_good_oe));
    chk("pg line", 32'h1, 32'(pg_line));
  endtask : t_startup

  task automatic t_modes;
    logic [4:0] codes [5] = '{5'h02, 5'h0F, 5'h10, 5'h1E, 5'h1F};
    logic [1:0] sel [5] = '{2'h0, 2'h2, 2'h0, 2'h3, 2'h1};
    int k;
    for (k = 0; k < 5; k++) begin
      code_req <= codes[k];
      fde_req <= sel[k][1];
      af_req <= sel[k][0];
      wait_sp(codes[k]);
      chk("mode out", 32'(exp_mode(codes[k], sel[k][1], sel[k][0])),
          32'({diode_emulation_mode, window_select_out, audio_filter_out}));
    end
  endtask : t_modes

  task automatic t_ctrl;
    logic [31:0] rd;
    bus(1'b1, OFS_CTRL, 32'h3, 4'hF, rd);
    bus(1'b1, OFS_CTRL, 32'h0, 4'h0, rd);
    bus(1'b1, 4'h6, 32'h0, 4'hF, rd);
    bus(1'b0, OFS_CTRL, 32'h0, 4'hF, rd);
    chk("ctrl readback", 32'h3, rd);
    chk("ccm forced", 32'h1, 32'(continuous_conduction_mode));
    bus(1'b0, OFS_MODE, 32'h0, 4'hF, rd);
    chk("mode reg ccm", 32'h1, 32'(rd[4]));
    bus(1'b0, 4'h2, 32'h0, 4'hF, rd);
    chk("unmapped read", 32'h0, rd);
    bus(1'b1, OFS_CTRL, 32'h1, 4'hF, rd);
  endtask : t_ctrl

  task automatic t_disable;
    logic [31:0] rd;
    on_req <= 1'b0;
    repeat (6) @(posedge core_clk);
    chk("oe when off", 32'h1, 32'(power_good_oe));
    chk("sp when off", 32'h0, 32'(dac_setpoint_out));
    chk("pg line off", 32'h0, 32'(pg_line));
    chk("pg data", 32'h0, 32'(power_good_out));
    on_req <= 1'b1;
    repeat (10) @(posedge core_clk);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF, rd);
    chk("state on again", 32'h2, 32'(rd[4:0]));
    fall_in <= 1'b1;
    repeat (6) @(posedge core_clk);
    bus(1'b0, OFS_STATUS, 32'h0, 4'hF, rd);
    chk("por bit low", 32'h0, 32'(rd[9]));
    chk("state supply low", 32'h1, 32'(rd[4:0]));
    chk("sp supply low", 32'h0, 32'(dac_setpoint_out));
  endtask : t_disable

  // the sequence needs some 5500 cycles; over three times that means a hang
  initial begin
    #(25 * 20000);
    n_fail++;
    stop_test();
  end

  initial begin
    t_reset();
    t_startup();
    t_modes();
    t_ctrl();
    t_disable();
    stop_test();
  end
endmodule : tb_vid_startup_sequencer

/* vss_host_model.sv */
// host-side model: drives id code, enable and mode pins, pulls up power-good
`timescale 1ns/1ps
module vss_host_model (
  input  wire logic       core_clk,
  input  wire logic       nrst,
  input  wire logic [4:0] code_req,
  input  wire logic       on_req,
  input  wire logic       af_req,
  input  wire logic       fde_req,
  input  wire logic       power_good_out,
  input  wire logic       power_good_oe,
  output logic [4:0]      voltage_id_bits,
  output logic            regulator_on_in,
  output logic            audio_filter_select,
  output logic            emulation_select,
  output wire logic       pg_line
);
  // all five bits launched together so the code never shows a mixed value
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      voltage_id_bits <= 5'h00;
      regulator_on_in <= 1'b0;
      audio_filter_select <= 1'b0;
      emulation_select <= 1'b0;
    end else begin
      voltage_id_bits <= code_req;
      regulator_on_in <= on_req;
      audio_filter_select <= af_req;
      emulation_select <= fde_req;
    end
  end
  // external pull-up: released line reads high
  assign pg_line = power_good_oe ? power_good_out : 1'b1;
endmodule : vss_host_model

/* vss_pkg.sv */
// constants, register map and state codes for the start-up sequencer
package vss_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ        = 40;
  localparam int unsigned START_DELAY_US = 100;
  localparam int unsigned START_DELAY_CYC = START_DELAY_US * CLK_MHZ;
  localparam logic [11:0] DELAY_LAST     = 12'(START_DELAY_CYC - 1);
  localparam int unsigned RAMP_TICK_CYC  = 16;
  localparam logic [3:0]  RAMP_TICK_LAST = 4'(RAMP_TICK_CYC - 1);
  localparam logic [3:0]  SW_CYCLES_LAST = 4'hC;

  // set-point in units of 10 uV
  localparam int unsigned SP_W    = 17;
  localparam logic [16:0] SP_TOP  = 17'h1F6EE;
  localparam logic [16:0] SP_STEP = 17'h00A0F;
  localparam logic [16:0] SP_LOW  = 17'h0A0F0;
  localparam logic [16:0] SP_ZERO = 17'h00000;
  localparam logic [4:0]  VID_LOW_CODE = 5'h1F;

  // band test: set-point * 10 >= target * 9
  localparam logic [3:0] BAND_NUM = 4'h9;
  localparam logic [3:0] BAND_DEN = 4'hA;

  // conduction window codes
  localparam logic [1:0] WIN_NOM = 2'h0;
  localparam logic [1:0] WIN_130 = 2'h1;
  localparam logic [1:0] WIN_150 = 2'h2;

  // register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_SETPT  = 4'h8;
  localparam logic [3:0] OFS_MODE   = 4'hC;

  // control register fields and reset
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_CCM_BIT = 1;
  localparam logic [1:0]  CTRL_RESET   = 2'h1;

  // status register fields
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_PG_BIT    = 8;
  localparam int unsigned ST_POR_BIT   = 9;
  localparam int unsigned ST_VID_LSB   = 16;

  typedef enum logic [4:0] {
    SEQ_OFF   = 5'h01,
    SEQ_DELAY = 5'h02,
    SEQ_RAMP  = 5'h04,
    SEQ_COUNT = 5'h08,
    SEQ_GOOD  = 5'h10
  } vss_state_e;

endpackage : vss_pkg

/* vss_sequencer.sv */
// start-up sequencer: vid decode, por gating, soft-start, power-good, mode select
`timescale 1ns/1ps

module vss_sequencer
  import vss_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic [4:0]  voltage_id_bits,
  input  wire logic        regulator_on_in,
  input  wire logic        supply_rise_threshold,
  input  wire logic        supply_fall_threshold,
  input  wire logic        switch_cycle_in,
  input  wire logic        audio_filter_select,
  input  wire logic        emulation_select,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic [16:0]      dac_setpoint_out,
  output logic             power_good_out,
  output logic             power_good_oe,
  output logic             continuous_conduction_mode,
  output logic             diode_emulation_mode,
  output logic [1:0]       window_select_out,
  output logic             audio_filter_out
);

  localparam int RAMP_BOUND = 900;

  // target set-point for a code
  function automatic logic [16:0] vid_target(input logic [4:0] code);
    logic [21:0] drop;
    drop = 22'(code) * 22'(SP_STEP);
    if (code == VID_LOW_CODE)
      return SP_LOW;
    return 17'(22'(SP_TOP) - drop);
  endfunction : vid_target

  // true once the set-point is at or above 90% of the target
  function automatic logic in_band(input logic [16:0] sp, input logic [16:0] tgt);
    logic [20:0] lhs;
    logic [20:0] rhs;
    lhs = 21'(sp) * 21'(BAND_DEN);
    rhs = 21'(tgt) * 21'(BAND_NUM);
    return lhs >= rhs;
  endfunction : in_band

  // mode table: {emulation, window[1:0], audio filter}
  function automatic logic [3:0] mode_decode(input logic mode2, input logic emul, input logic afsel);
    if (!mode2)
      return emul ? {1'b1, WIN_130, 1'b0} : {1'b0, WIN_NOM, 1'b0};
    if (!afsel)
      return {1'b1, WIN_150, 1'b0};
    return emul ? {1'b1, WIN_130, 1'b0} : {1'b1, WIN_130, 1'b1};
  endfunction : mode_decode

  vss_state_e  state_reg;
  vss_state_e  state_next;
  logic        por_ok_reg;
  logic [1:0]  ctrl_reg;
  logic [11:0] delay_cnt_reg;
  logic [3:0]  sw_cnt_reg;
  logic [16:0] setpoint_reg;
  logic        ccm_reg;
  logic        dem_reg;
  logic [1:0]  window_reg;
  logic        af_reg;
  logic        pg_oe_reg;
  logic        wait_reg;
  logic [31:0] rdata_reg;

  logic        enabled;
  logic [16:0] target_w;
  logic        ramp_tick;
  logic        soft_start;
  logic [3:0]  mode_w;
  logic        bus_req;
  logic        bus_done;
  logic        addr_ok;

  assign target_w   = vid_target(voltage_id_bits);
  assign enabled    = por_ok_reg && regulator_on_in && ctrl_reg[CTRL_EN_BIT];
  assign soft_start = (state_reg == SEQ_DELAY) || (state_reg == SEQ_RAMP) || (state_reg == SEQ_COUNT);
  assign mode_w     = mode_decode(voltage_id_bits[4], emulation_select, audio_filter_select);

  // supply monitor with hysteresis; falling crossing wins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      por_ok_reg <= 1'b0;
    else if (supply_fall_threshold)
      por_ok_reg <= 1'b0;
    else if (supply_rise_threshold)
      por_ok_reg <= 1'b1;
  end

  vss_tick_div u_tick (
    .core_clk (core_clk),
    .nrst     (nrst),
    .run      (enabled),
    .tick     (ramp_tick)
  );

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SEQ_OFF: begin
        if (enabled)
          state_next = SEQ_DELAY;
      end
      SEQ_DELAY: begin
        if (delay_cnt_reg == DELAY_LAST)
          state_next = SEQ_RAMP;
      end
      SEQ_RAMP: begin
        if (in_band(setpoint_reg, target_w))
          state_next = SEQ_COUNT;
      end
      SEQ_COUNT: begin
        if (switch_cycle_in && sw_cnt_reg == SW_CYCLES_LAST)
          state_next = SEQ_GOOD;
      end
      SEQ_GOOD: begin
        state_next = SEQ_GOOD;
      end
      default: begin
        state_next = SEQ_OFF;
      end
    endcase
    if (!enabled)
      state_next = SEQ_OFF;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      state_reg <= SEQ_OFF;
    else
      state_reg <= state_next;
  end

  // start-up delay counter
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      delay_cnt_reg <= 12'h000;
    else if (state_reg == SEQ_DELAY && enabled)
      delay_cnt_reg <= delay_cnt_reg + 12'h001;
    else
      delay_cnt_reg <= 12'h000;
  end

  // switching cycle counter, armed only once in band
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      sw_cnt_reg <= 4'h0;
    else if (state_reg != SEQ_COUNT)
      sw_cnt_reg <= 4'h0;
    else if (switch_cycle_in)
      sw_cnt_reg <= sw_cnt_reg + 4'h1;
  end

  // set-point ramp; keeps slewing after release so id changes also move gently
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      setpoint_reg <= SP_ZERO;
    end else if (state_reg == SEQ_OFF || state_reg == SEQ_DELAY) begin
      setpoint_reg <= SP_ZERO;
    end else if (ramp_tick) begin
      if (setpoint_reg < target_w)
        setpoint_reg <= (target_w - setpoint_reg > SP_STEP) ? setpoint_reg + SP_STEP : target_w;
      else if (setpoint_reg > target_w)
        setpoint_reg <= (setpoint_reg - target_w > SP_STEP) ? setpoint_reg - SP_STEP : target_w;
    end
  end

  // conduction mode outputs
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ccm_reg    <= 1'b1;
      dem_reg    <= 1'b0;
      window_reg <= WIN_NOM;
      af_reg     <= 1'b0;
    end else if (soft_start || state_reg == SEQ_OFF || ctrl_reg[CTRL_CCM_BIT]) begin
      ccm_reg    <= 1'b1;
      dem_reg    <= 1'b0;
      window_reg <= WIN_NOM;
      af_reg     <= 1'b0;
    end else begin
      dem_reg    <= mode_w[3];
      ccm_reg    <= !mode_w[3];
      window_reg <= mode_w[2:1];
      af_reg     <= mode_w[0];
    end
  end

  // power-good pull-down; released only in the good state
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      pg_oe_reg <= 1'b1;
    else
      pg_oe_reg <= (state_reg != SEQ_GOOD);
  end

  // avalon slave: one wait cycle, then the request completes
  assign bus_req  = avs_read || avs_write;
  assign bus_done = bus_req && !wait_reg;
  assign addr_ok  = (avs_address[1:0] == 2'h0);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      wait_reg <= 1'b1;
    else if (!wait_reg)
      wait_reg <= 1'b1;
    else if (bus_req)
      wait_reg <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      ctrl_reg <= CTRL_RESET;
    else if (bus_done && avs_write && avs_address == OFS_CTRL && avs_byteenable[0])
      ctrl_reg <= avs_writedata[1:0];
  end

  // read data captured with the first wait cycle, stands in the completing cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (avs_read && wait_reg) begin
      rdata_reg <= 32'h0000_0000;
      if (addr_ok) begin
        case (avs_address)
          OFS_CTRL: begin
            rdata_reg[1:0] <= ctrl_reg;
          end
          OFS_STATUS: begin
            rdata_reg[ST_STATE_LSB +: 5] <= state_reg;
            rdata_reg[ST_PG_BIT]         <= !pg_oe_reg;
            rdata_reg[ST_POR_BIT]        <= por_ok_reg;
            rdata_reg[ST_VID_LSB +: 5]   <= voltage_id_bits;
          end
          OFS_SETPT: begin
            rdata_reg[16:0] <= setpoint_reg;
          end
          OFS_MODE: begin
            rdata_reg[4:0] <= {ccm_reg, dem_reg, window_reg, af_reg};
          end
          default: begin
            rdata_reg <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  assign avs_readdata               = rdata_reg;
  assign avs_waitrequest            = wait_reg;
  assign dac_setpoint_out           = setpoint_reg;
  assign power_good_oe              = pg_oe_reg;
  assign continuous_conduction_mode = ccm_reg;
  assign diode_emulation_mode       = dem_reg;
  assign window_select_out          = window_reg;
  assign audio_filter_out           = af_reg;

  // the pin only ever pulls low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst)
      power_good_out <= 1'b0;
    else
      power_good_out <= 1'b0;
  end

  // ---- assertions ----
  sequence s_delay_done;
    state_reg == SEQ_DELAY && delay_cnt_reg == DELAY_LAST && enabled;
  endsequence

  sequence s_count_done;
    state_reg == SEQ_COUNT && switch_cycle_in && sw_cnt_reg == SW_CYCLES_LAST && enabled;
  endsequence

  a_off_zero_sp: assert property (@(posedge core_clk) disable iff (!nrst)
    !enabled |=> state_reg == SEQ_OFF ##1 setpoint_reg == SP_ZERO)
    else $error("set-point not zero after disable");

  a_por_gate: assert property (@(posedge core_clk) disable iff (!nrst)
    supply_fall_threshold |=> !por_ok_reg ##1 state_reg == SEQ_OFF)
    else $error("falling supply did not disable");

  a_delay_exact: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg == SEQ_RAMP && $past(state_reg) == SEQ_DELAY |-> $past(delay_cnt_reg) == DELAY_LAST)
    else $error("soft-start began before delay ended");

  a_delay_exit: assert property (@(posedge core_clk) disable iff (!nrst)
    s_delay_done |=> state_reg == SEQ_RAMP)
    else $error("delay did not end on time");

  a_count_exact: assert property (@(posedge core_clk) disable iff (!nrst)
    s_count_done |=> state_reg == SEQ_GOOD ##1 !power_good_oe)
    else $error("power-good not released after switching count");

  a_good_needs_count: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg == SEQ_GOOD && $past(state_reg) == SEQ_COUNT |-> $past(sw_cnt_reg) == SW_CYCLES_LAST)
    else $error("power-good released with short count");

  a_pg_low: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg != SEQ_GOOD |=> power_good_oe && !power_good_out)
    else $error("power-good not pulled low");

  a_ccm_soft: assert property (@(posedge core_clk) disable iff (!nrst)
    soft_start |=> continuous_conduction_mode && !diode_emulation_mode)
    else $error("conduction not forced during soft-start");

  a_ramp_settle: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(state_reg == SEQ_RAMP) |-> ##[1:RAMP_BOUND] (setpoint_reg == target_w || state_reg == SEQ_OFF))
    else $error("ramp did not reach target");

  a_mode1_off: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg == SEQ_GOOD && !ctrl_reg[CTRL_CCM_BIT] && !voltage_id_bits[4] && !emulation_select
      |=> !diode_emulation_mode && window_select_out == WIN_NOM)
    else $error("mode 1 emulation not disabled");

  a_mode2_filter: assert property (@(posedge core_clk) disable iff (!nrst)
    state_reg == SEQ_GOOD && !ctrl_reg[CTRL_CCM_BIT] && voltage_id_bits[4] && audio_filter_select
      && !emulation_select |=> audio_filter_out && window_select_out == WIN_130)
    else $error("mode 2 audio filter not selected");

  a_bus_one_wait: assert property (@(posedge core_clk) disable iff (!nrst)
    bus_req && wait_reg |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after one wait cycle");

endmodule : vss_sequencer

/* vss_tick_div.sv */
// ramp step divider: one-cycle enable pulse every RAMP_TICK_CYC cycles
`timescale 1ns/1ps
module vss_tick_div
  import vss_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic run,
  output logic      tick
);

  logic [3:0] div_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 4'h0;
      tick    <= 1'b0;
    end else if (!run) begin
      div_reg <= 4'h0;
      tick    <= 1'b0;
    end else begin
      tick    <= (div_reg == RAMP_TICK_LAST);
      div_reg <= (div_reg == RAMP_TICK_LAST) ? 4'h0 : div_reg + 4'h1;
    end
  end

endmodule : vss_tick_div
